// ==== hw/esc_checker.sv ====
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
// Summary of operation
// - first sixteen record bytes must equal the fixed first header pattern.
// - sixteen bytes at offset 24 must equal the fixed second header pattern.
// - build date word at offset 20 is extracted; year, month, day in hex digits.
// - software word at offset 40 is extracted and passed through untouched.
// - public key modulus is 384 bytes starting at offset 128.
// - big integers are stored least significant byte first, top byte at start+383.
// - signature at offset 516 is checked by the modular engine, padded-digest scheme.
// - quotients at 1040 and 1424 feed the modular engine's reduction check.
// - digest at 960 is eight little-endian doublewords.
// - attributes at 928 and attribute mask at 944 are extracted.
// - product identifier at 1024 and security version at 1026 are extracted.
module esc_checker (
  // clock and reset
  input  wire logic                 I_MCLK,
  input  wire logic                 I_ARST_N,
  // apb slave
  input  wire logic                 I_PSEL,
  input  wire logic                 I_PENABLE,
  input  wire logic                 I_PWRITE,
  input  wire logic [7:0]           I_PADDR,
  input  wire logic [31:0]          I_PWDATA,
  output logic      [31:0]          O_PRDATA,
  output logic                      O_PREADY,
  output logic                      O_PSLVERR,
  // record memory read port
  output esc_pkg::esc_mem_req_t     O_MEM,
  input  wire logic                 I_MEM_ACK,
  input  wire logic [31:0]          I_MEM_RDATA,
  // big integer stream to modular engine
  output esc_pkg::esc_bn_word_t     O_BN,
  input  wire logic                 I_BN_DONE,
  input  wire logic                 I_BN_PASS,
  // interrupt and result
  output logic                      O_IRQ,
  output logic                      O_FAIL
);

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_ENGINE = 4'b0100,
    ST_DONE  = 4'b1000
  } esc_state_t;

  esc_state_t   state_q;
  logic [8:0]   word_q;
  logic [31:0]  base_q;
  logic [31:0]  date_q;
  logic [31:0]  swdef_q;
  logic [31:0]  sel_q;
  logic [31:0]  selmask_q;
  logic [31:0]  prodsvn_q;
  logic [31:0]  attr_q   [4];
  logic [31:0]  amask_q  [4];
  logic [31:0]  digest_q [8];
  logic         hdr1_bad_q;
  logic         hdr2_bad_q;
  logic         exp_bad_q;
  logic         rsv_bad_q;
  logic         date_bad_q;
  logic         bn_bad_q;
  logic         pass_q;
  logic         fail_q;
  logic [1:0]   int_stat_q;
  logic [1:0]   int_mask_q;
  esc_pkg::esc_bn_word_t bn_q;

  logic         wr_en;
  logic         rd_en;
  logic         start;
  logic         take;
  logic         last_word;
  logic         ev_done;
  logic         ev_fail;
  logic         chk_fail;

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic in_range(input logic [8:0] w, input logic [8:0] lo,
                                    input int unsigned n);
    in_range = (w >= lo) && ({23'h0, w} < ({23'h0, lo} + n));
  endfunction

  function automatic logic digits_ok(input logic [7:0] v, input logic [7:0] hi);
    digits_ok = (v[3:0] <= 4'h9) && (v[7:4] <= 4'h9) && (v != 8'h00) && (v <= hi);
  endfunction

  function automatic logic [31:0] hdr_word(input logic [127:0] pat, input logic [1:0] i);
    hdr_word = pat[{i, 5'h00} +: 32];
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // apb decode

  assign wr_en     = I_PSEL && I_PENABLE && I_PWRITE;
  assign rd_en     = I_PSEL && I_PENABLE && !I_PWRITE;
  assign start     = wr_en && (I_PADDR == esc_pkg::A_CTRL) && I_PWDATA[0] &&
                     (state_q != ST_FETCH) && (state_q != ST_ENGINE);
  assign take      = (state_q == ST_FETCH) && I_MEM_ACK;
  assign last_word = ({23'h0, word_q} == (esc_pkg::REC_WORDS - 1));
  assign O_PREADY  = 1'b1;

  always_comb begin
    O_PRDATA  = 32'h0000_0000;
    O_PSLVERR = 1'b0;
    if (!rd_en && !wr_en) begin
      O_PSLVERR = 1'b0;
    end else if (I_PADDR == esc_pkg::A_CTRL) begin
      O_PRDATA = 32'h0000_0000;
    end else if (I_PADDR == esc_pkg::A_BASE) begin
      O_PRDATA = base_q;
    end else if (I_PADDR == esc_pkg::A_STATUS) begin
      O_PRDATA[esc_pkg::S_BUSY] = (state_q == ST_FETCH) || (state_q == ST_ENGINE);
      O_PRDATA[esc_pkg::S_PASS] = pass_q;
      O_PRDATA[esc_pkg::S_FAIL] = fail_q;
      O_PRDATA[esc_pkg::S_HDR1] = hdr1_bad_q;
      O_PRDATA[esc_pkg::S_HDR2] = hdr2_bad_q;
      O_PRDATA[esc_pkg::S_EXP]  = exp_bad_q;
      O_PRDATA[esc_pkg::S_RSV]  = rsv_bad_q;
      O_PRDATA[esc_pkg::S_DATE] = date_bad_q;
      O_PRDATA[esc_pkg::S_BN]   = bn_bad_q;
    end else if (I_PADDR == esc_pkg::A_INT_STAT) begin
      O_PRDATA[1:0] = int_stat_q;
    end else if (I_PADDR == esc_pkg::A_INT_MASK) begin
      O_PRDATA[1:0] = int_mask_q;
    end else if (I_PADDR == esc_pkg::A_DATE) begin
      O_PRDATA = date_q;
    end else if (I_PADDR == esc_pkg::A_SWDEF) begin
      O_PRDATA = swdef_q;
    end else if (I_PADDR == esc_pkg::A_SEL) begin
      O_PRDATA = sel_q;
    end else if (I_PADDR == esc_pkg::A_SELMASK) begin
      O_PRDATA = selmask_q;
    end else if (I_PADDR == esc_pkg::A_PRODSVN) begin
      O_PRDATA = prodsvn_q;
    end else if (I_PADDR[7:4] == esc_pkg::A_ATTR[7:4] && I_PADDR[1:0] == 2'h0) begin
      O_PRDATA = attr_q[I_PADDR[3:2]];
    end else if (I_PADDR[7:4] == esc_pkg::A_AMASK[7:4] && I_PADDR[1:0] == 2'h0) begin
      O_PRDATA = amask_q[I_PADDR[3:2]];
    end else if (I_PADDR[7:5] == esc_pkg::A_DIGEST[7:5] && I_PADDR[1:0] == 2'h0) begin
      O_PRDATA = digest_q[I_PADDR[4:2]];
    end else begin
      O_PSLVERR = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // control registers

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      base_q <= esc_pkg::BASE_RESET;
    end else if (wr_en && I_PADDR == esc_pkg::A_BASE) begin
      // low bits forced clear: record sits on a page boundary
      base_q <= {I_PWDATA[31:12], 12'h000};
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      int_mask_q <= esc_pkg::INT_RESET;
    end else if (wr_en && I_PADDR == esc_pkg::A_INT_MASK) begin
      int_mask_q <= I_PWDATA[1:0];
    end
  end

  // sticky events, write one to clear, set wins
  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      int_stat_q <= esc_pkg::INT_RESET;
    end else begin
      int_stat_q <= (int_stat_q & ~((wr_en && I_PADDR == esc_pkg::A_INT_STAT) ?
                                    I_PWDATA[1:0] : 2'h0)) | {ev_fail, ev_done};
    end
  end

  assign O_IRQ  = |(int_stat_q & int_mask_q);
  assign O_FAIL = fail_q;

  ////////////////////////////////////////////////////////////////////////////////
  // sequencer

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (start) begin
            state_q <= ST_FETCH;
          end
        end
        ST_FETCH: begin
          if (take && last_word) begin
            state_q <= ST_ENGINE;
          end
        end
        ST_ENGINE: begin
          if (I_BN_DONE) begin
            state_q <= ST_DONE;
          end
        end
        ST_DONE: begin
          if (start) begin
            state_q <= ST_FETCH;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      word_q <= 9'h000;
    end else if (start) begin
      word_q <= 9'h000;
    end else if (take && !last_word) begin
      word_q <= word_q + 9'h001;
    end
  end

  assign O_MEM = '{req:  (state_q == ST_FETCH),
                   addr: base_q + {21'h0, word_q, 2'h0}};

  ////////////////////////////////////////////////////////////////////////////////
  // field capture

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      date_q    <= 32'h0000_0000;
      swdef_q   <= 32'h0000_0000;
      sel_q     <= 32'h0000_0000;
      selmask_q <= 32'h0000_0000;
      prodsvn_q <= 32'h0000_0000;
      attr_q    <= '{default: 32'h0000_0000};
      amask_q   <= '{default: 32'h0000_0000};
      digest_q  <= '{default: 32'h0000_0000};
    end else if (take) begin
      if (word_q == esc_pkg::W_DATE) begin
        date_q <= I_MEM_RDATA;
      end
      if (word_q == esc_pkg::W_SWDEF) begin
        swdef_q <= I_MEM_RDATA;
      end
      if (word_q == esc_pkg::W_SEL) begin
        sel_q <= I_MEM_RDATA;
      end
      if (word_q == esc_pkg::W_SELMASK) begin
        selmask_q <= I_MEM_RDATA;
      end
      if (word_q == esc_pkg::W_PRODSVN) begin
        prodsvn_q <= I_MEM_RDATA;
      end
      if (in_range(word_q, esc_pkg::W_ATTR, 4)) begin
        attr_q[word_q[1:0]] <= I_MEM_RDATA;
      end
      if (in_range(word_q, esc_pkg::W_AMASK, 4)) begin
        amask_q[word_q[1:0]] <= I_MEM_RDATA;
      end
      if (in_range(word_q, esc_pkg::W_DIGEST, 8)) begin
        // each doubleword arrives little-endian, kept as read
        digest_q[word_q[2:0]] <= I_MEM_RDATA;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // content checks

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      hdr1_bad_q <= 1'b0;
      hdr2_bad_q <= 1'b0;
      exp_bad_q  <= 1'b0;
      rsv_bad_q  <= 1'b0;
      date_bad_q <= 1'b0;
    end else if (start) begin
      hdr1_bad_q <= 1'b0;
      hdr2_bad_q <= 1'b0;
      exp_bad_q  <= 1'b0;
      rsv_bad_q  <= 1'b0;
      date_bad_q <= 1'b0;
    end else if (take) begin
      if (in_range(word_q, esc_pkg::W_HDR1, 4) &&
          I_MEM_RDATA != hdr_word(esc_pkg::HDR1_BYTES, word_q[1:0])) begin
        hdr1_bad_q <= 1'b1;
      end
      if (in_range(word_q, esc_pkg::W_HDR2, 4) &&
          I_MEM_RDATA != hdr_word(esc_pkg::HDR2_BYTES, word_q[1:0] - 2'h2)) begin
        hdr2_bad_q <= 1'b1;
      end
      if (word_q == esc_pkg::W_EXP && I_MEM_RDATA != esc_pkg::EXP_VALUE) begin
        exp_bad_q <= 1'b1;
      end
      if ((in_range(word_q, esc_pkg::W_RSV0, 21) || in_range(word_q, esc_pkg::W_RSV1, 5) ||
           in_range(word_q, esc_pkg::W_RSV2, 8) || in_range(word_q, esc_pkg::W_RSV3, 3)) &&
          I_MEM_RDATA != 32'h0000_0000) begin
        rsv_bad_q <= 1'b1;
      end
      if (word_q == esc_pkg::W_DATE &&
          !(digits_ok(I_MEM_RDATA[15:8], 8'h12) && digits_ok(I_MEM_RDATA[7:0], 8'h31))) begin
        date_bad_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // big integer stream, least significant word first

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      bn_q <= '0;
    end else begin
      bn_q.valid <= 1'b0;
      bn_q.last  <= 1'b0;
      if (take) begin
        bn_q.data <= I_MEM_RDATA;
        if (in_range(word_q, esc_pkg::W_MOD, esc_pkg::BN_WORDS)) begin
          bn_q.valid <= 1'b1;
          bn_q.field <= esc_pkg::BN_MOD;
          bn_q.index <= 7'(word_q - esc_pkg::W_MOD);
        end else if (in_range(word_q, esc_pkg::W_SIG, esc_pkg::BN_WORDS)) begin
          bn_q.valid <= 1'b1;
          bn_q.field <= esc_pkg::BN_SIG;
          bn_q.index <= 7'(word_q - esc_pkg::W_SIG);
        end else if (in_range(word_q, esc_pkg::W_Q1, esc_pkg::BN_WORDS)) begin
          bn_q.valid <= 1'b1;
          bn_q.field <= esc_pkg::BN_Q1;
          bn_q.index <= 7'(word_q - esc_pkg::W_Q1);
        end else if (in_range(word_q, esc_pkg::W_Q2, esc_pkg::BN_WORDS)) begin
          bn_q.valid <= 1'b1;
          bn_q.field <= esc_pkg::BN_Q2;
          bn_q.index <= 7'(word_q - esc_pkg::W_Q2);
          bn_q.last  <= last_word;
        end
      end
    end
  end

  assign O_BN = bn_q;

  ////////////////////////////////////////////////////////////////////////////////
  // verdict

  assign chk_fail = hdr1_bad_q || hdr2_bad_q || exp_bad_q || rsv_bad_q;
  assign ev_done  = (state_q == ST_ENGINE) && I_BN_DONE;
  assign ev_fail  = ev_done && (chk_fail || !I_BN_PASS);

  always_ff @(posedge I_MCLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      pass_q   <= 1'b0;
      fail_q   <= 1'b0;
      bn_bad_q <= 1'b0;
    end else if (start) begin
      pass_q   <= 1'b0;
      fail_q   <= 1'b0;
      bn_bad_q <= 1'b0;
    end else if (ev_done) begin
      pass_q   <= !chk_fail && I_BN_PASS;
      fail_q   <= chk_fail || !I_BN_PASS;
      bn_bad_q <= !I_BN_PASS;
    end
  end

endmodule

// ==== pkg/esc_pkg.sv ====
package esc_pkg;

  // record geometry, in 32-bit words except the page size in bytes
  localparam int unsigned REC_WORDS    = 452;
  localparam int unsigned BN_WORDS     = 96;
  localparam int unsigned PAGE_BYTES   = 4096;

  // field word positions
  localparam logic [8:0] W_HDR1        = 9'h000;
  localparam logic [8:0] W_DATE        = 9'h005;
  localparam logic [8:0] W_HDR2        = 9'h006;
  localparam logic [8:0] W_SWDEF       = 9'h00a;
  localparam logic [8:0] W_RSV0        = 9'h00b;
  localparam logic [8:0] W_MOD         = 9'h020;
  localparam logic [8:0] W_EXP         = 9'h080;
  localparam logic [8:0] W_SIG         = 9'h081;
  localparam logic [8:0] W_SEL         = 9'h0e1;
  localparam logic [8:0] W_SELMASK     = 9'h0e2;
  localparam logic [8:0] W_RSV1        = 9'h0e3;
  localparam logic [8:0] W_ATTR        = 9'h0e8;
  localparam logic [8:0] W_AMASK       = 9'h0ec;
  localparam logic [8:0] W_DIGEST      = 9'h0f0;
  localparam logic [8:0] W_RSV2        = 9'h0f8;
  localparam logic [8:0] W_PRODSVN     = 9'h100;
  localparam logic [8:0] W_RSV3        = 9'h101;
  localparam logic [8:0] W_Q1          = 9'h104;
  localparam logic [8:0] W_Q2          = 9'h164;

  // fixed contents, byte 0 in bits 7:0 of each word
  localparam logic [127:0] HDR1_BYTES  = 128'h00000000_00010000_000000e1_00000006;
  localparam logic [127:0] HDR2_BYTES  = 128'h00000001_00000000_06000060_00000101;
  localparam logic [31:0]  EXP_VALUE   = 32'h0000_0003;

  // register byte offsets
  localparam logic [7:0] A_CTRL        = 8'h00;
  localparam logic [7:0] A_BASE        = 8'h04;
  localparam logic [7:0] A_STATUS      = 8'h08;
  localparam logic [7:0] A_INT_STAT    = 8'h0c;
  localparam logic [7:0] A_INT_MASK    = 8'h10;
  localparam logic [7:0] A_DATE        = 8'h14;
  localparam logic [7:0] A_SWDEF       = 8'h18;
  localparam logic [7:0] A_SEL         = 8'h1c;
  localparam logic [7:0] A_SELMASK     = 8'h20;
  localparam logic [7:0] A_PRODSVN     = 8'h24;
  localparam logic [7:0] A_ATTR        = 8'h40;
  localparam logic [7:0] A_AMASK       = 8'h50;
  localparam logic [7:0] A_DIGEST      = 8'h60;

  // status bit positions
  localparam int unsigned S_BUSY       = 0;
  localparam int unsigned S_PASS       = 1;
  localparam int unsigned S_FAIL       = 2;
  localparam int unsigned S_HDR1       = 3;
  localparam int unsigned S_HDR2       = 4;
  localparam int unsigned S_EXP        = 5;
  localparam int unsigned S_RSV        = 6;
  localparam int unsigned S_DATE       = 7;
  localparam int unsigned S_BN         = 8;

  // interrupt bits: 0 done, 1 fail
  localparam logic [1:0]  INT_RESET    = 2'h0;
  localparam logic [31:0] BASE_RESET   = 32'h0000_0000;

  typedef enum logic [1:0] {
    BN_MOD = 2'h0,
    BN_SIG = 2'h1,
    BN_Q1  = 2'h2,
    BN_Q2  = 2'h3
  } esc_bn_field_t;

  typedef struct packed {
    logic        req;
    logic [31:0] addr;
  } esc_mem_req_t;

  typedef struct packed {
    logic          valid;
    logic          last;
    esc_bn_field_t field;
    logic [6:0]    index;
    logic [31:0]   data;
  } esc_bn_word_t;

endpackage

// ==== tb/esc_checker_properties.sv ====
`timescale 1ns/100ps
module esc_checker_properties (
  // clock and reset
  input wire logic                  I_MCLK,
  input wire logic                  I_ARST_N,
  // apb
  input wire logic                  I_PSEL,
  input wire logic                  I_PENABLE,
  input wire logic                  I_PWRITE,
  input wire logic [7:0]            I_PADDR,
  input wire logic [31:0]           I_PWDATA,
  input wire logic [31:0]           O_PRDATA,
  input wire logic                  O_PREADY,
  input wire logic                  O_PSLVERR,
  // memory, engine, result
  input wire esc_pkg::esc_mem_req_t O_MEM,
  input wire logic                  I_MEM_ACK,
  input wire logic [31:0]           I_MEM_RDATA,
  input wire esc_pkg::esc_bn_word_t O_BN,
  input wire logic                  I_BN_DONE,
  input wire logic                  I_BN_PASS,
  input wire logic                  O_IRQ,
  input wire logic                  O_FAIL
);
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_ARST_N);
  //////////////////////////////////////////////////
  sequence s_last;
    O_BN.valid && O_BN.last;
  endsequence
  sequence s_reject;
    I_BN_DONE && !I_BN_PASS;
  endsequence
  //////////////////////////////////////////////////
  chk_mem_hold: assert property (O_MEM.req && !I_MEM_ACK |=> O_MEM.req && $stable(O_MEM.addr))
    else $error("memory request changed before ack");
  chk_addr_step: assert property ((O_MEM.req && I_MEM_ACK) ##1 O_MEM.req |->
    O_MEM.addr == $past(O_MEM.addr) + 32'h4)
    else $error("memory address did not step by one word");
  chk_addr_page: assert property (O_MEM.req |-> O_MEM.addr[11:0] <= 12'h70c && O_MEM.addr[1:0] == 2'h0)
    else $error("memory address outside the record page");
  chk_bn_data: assert property (O_BN.valid |-> $past(O_MEM.req && I_MEM_ACK)
    && O_BN.data == $past(I_MEM_RDATA))
    else $error("bignum word not the word just fetched");
  chk_bn_index: assert property (O_BN.valid ##2 O_BN.valid |-> O_BN.index == $past(O_BN.index, 2) + 7'h1
    || (O_BN.index == 7'h0 && $past(O_BN.index, 2) == 7'h5f))
    else $error("bignum index out of order");
  chk_last_q2: assert property (s_last |-> O_BN.field == esc_pkg::BN_Q2 && O_BN.index == 7'h5f)
    else $error("last bignum word not top of second quotient");
  chk_fail_rise: assert property ($rose(O_FAIL) |-> $past(I_BN_DONE))
    else $error("fail rose without engine done");
  chk_reject_fail: assert property (s_last ##2 s_reject |=> O_FAIL)
    else $error("engine reject did not raise fail");
endmodule
bind esc_checker esc_checker_properties esc_checker_properties_i (
  .I_MCLK(I_MCLK), .I_ARST_N(I_ARST_N), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
  .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
  .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_MEM(O_MEM), .I_MEM_ACK(I_MEM_ACK),
  .I_MEM_RDATA(I_MEM_RDATA), .O_BN(O_BN), .I_BN_DONE(I_BN_DONE), .I_BN_PASS(I_BN_PASS),
  .O_IRQ(O_IRQ), .O_FAIL(O_FAIL));

// ==== tb/esc_mem_model.sv ====
`timescale 1ns/100ps
module esc_mem_model (
  // clock and reset
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  // request side
  input  wire esc_pkg::esc_mem_req_t i_mem,
  input  wire logic [3:0]            i_delay,
  // answer side
  output logic                       o_ack,
  output logic [31:0]                o_rdata
);
  // record image, filled by the bench before each run
  logic [31:0] rec [esc_pkg::REC_WORDS];
  logic [3:0]  wait_q;
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_ack   <= 1'b0;
      o_rdata <= 32'h0;
      wait_q  <= 4'h0;
    end else if (i_mem.req && !o_ack && wait_q == i_delay) begin
      // word index is the page offset, record is page aligned
      o_ack   <= 1'b1;
      o_rdata <= rec[i_mem.addr[10:2]];
      wait_q  <= 4'h0;
    end else begin
      // released data lines invert each cycle, showing the last word every other cycle
      o_ack   <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_q  <= (i_mem.req && !o_ack) ? wait_q + 4'h1 : 4'h0;
    end
  end
endmodule

// ==== tb/esc_checker_tb.sv ====
`timescale 1ns/100ps
module esc_checker_tb;
  logic                  mclk;
  logic                  arst_n;
  logic                  psel;
  logic                  penable;
  logic                  pwrite;
  logic [7:0]            paddr;
  logic [31:0]           pwdata;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  esc_pkg::esc_mem_req_t mem;
  logic                  mem_ack;
  logic [31:0]           mem_rdata;
  esc_pkg::esc_bn_word_t bn;
  logic                  bn_done;
  logic                  bn_pass;
  logic                  irq;
  logic                  fail;
  logic [3:0]            delay;
  logic                  last_d;
  logic [31:0]           rd;
  logic                  err;
  int                    n_mismatch;
  int                    tests_run;
  int                    n_bn;
  localparam logic [8:0] FBASE [4] = '{esc_pkg::W_MOD, esc_pkg::W_SIG, esc_pkg::W_Q1,
                                       esc_pkg::W_Q2};
  // register address beside the record word it must show
  localparam logic [16:0] ROWS [11] = '{
    {esc_pkg::A_DATE, esc_pkg::W_DATE}, {esc_pkg::A_SWDEF, esc_pkg::W_SWDEF},
    {esc_pkg::A_SEL, esc_pkg::W_SEL}, {esc_pkg::A_SELMASK, esc_pkg::W_SELMASK},
    {esc_pkg::A_PRODSVN, esc_pkg::W_PRODSVN}, {esc_pkg::A_ATTR, esc_pkg::W_ATTR},
    {esc_pkg::A_ATTR + 8'h0c, esc_pkg::W_ATTR + 9'h3}, {esc_pkg::A_AMASK, esc_pkg::W_AMASK},
    {esc_pkg::A_AMASK + 8'h0c, esc_pkg::W_AMASK + 9'h3}, {esc_pkg::A_DIGEST, esc_pkg::W_DIGEST},
    {esc_pkg::A_DIGEST + 8'h1c, esc_pkg::W_DIGEST + 9'h7}};
  // corrupted word, its value, expected status
  localparam logic [52:0] BAD [9] = '{
    {esc_pkg::W_HDR1, 32'h7, 12'h00c}, {esc_pkg::W_HDR2 + 9'h1, 32'h0, 12'h014},
    {esc_pkg::W_EXP, 32'h4, 12'h024}, {esc_pkg::W_RSV0, 32'h1, 12'h044},
    {esc_pkg::W_RSV1 + 9'h4, 32'h8000_0000, 12'h044}, {esc_pkg::W_RSV2 + 9'h7, 32'h1, 12'h044},
    {esc_pkg::W_RSV3 + 9'h2, 32'h100, 12'h044}, {esc_pkg::W_DATE, 32'h2017_1315, 12'h082},
    {esc_pkg::W_SWDEF, 32'h0, 12'h104}};
  //////////////////////////////////////////////////
  esc_checker esc_checker_i (
    .I_MCLK(mclk), .I_ARST_N(arst_n), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready),
    .O_PSLVERR(pslverr), .O_MEM(mem), .I_MEM_ACK(mem_ack), .I_MEM_RDATA(mem_rdata),
    .O_BN(bn), .I_BN_DONE(bn_done), .I_BN_PASS(bn_pass), .O_IRQ(irq), .O_FAIL(fail));
  esc_mem_model mem_i (
    .i_clk(mclk), .i_rst_n(arst_n), .i_mem(mem), .i_delay(delay), .o_ack(mem_ack),
    .o_rdata(mem_rdata));
  //////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // answer taken at the rising edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      rd  = prdata;
      err = pslverr;
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // valid record: fixed headers, exponent, zero reserved, select within mask
  task automatic build();
    for (int w = 0; w < esc_pkg::REC_WORDS; w++) mem_i.rec[w] = 32'h5a00_0000 | 32'(w * 3);
    for (int w = 0; w < 21; w++) begin
      mem_i.rec[esc_pkg::W_RSV0 + w] = 32'h0;
      if (w < 5) mem_i.rec[esc_pkg::W_RSV1 + w] = 32'h0;
      if (w < 8) mem_i.rec[esc_pkg::W_RSV2 + w] = 32'h0;
      if (w < 3) mem_i.rec[esc_pkg::W_RSV3 + w] = 32'h0;
      if (w < 4) mem_i.rec[esc_pkg::W_HDR1 + w] = esc_pkg::HDR1_BYTES[32*w +: 32];
      if (w < 4) mem_i.rec[esc_pkg::W_HDR2 + w] = esc_pkg::HDR2_BYTES[32*w +: 32];
    end
    mem_i.rec[esc_pkg::W_DATE] = 32'h2017_0715;
    mem_i.rec[esc_pkg::W_EXP]  = esc_pkg::EXP_VALUE;
    mem_i.rec[esc_pkg::W_SEL]  = 32'h00ff_00f0 & mem_i.rec[esc_pkg::W_SELMASK];
  endtask
  task automatic run(input logic pass);
    int n;
    n = 0;
    n_bn = 0;
    bn_pass <= pass;
    apb(1'b1, esc_pkg::A_CTRL, 32'h1);
    while (bn_done !== 1'b1 && n < 20000) begin
      @(posedge mclk);
      n++;
    end
    check(bn_done, 1'b1, "engine done");
    repeat (3) @(posedge mclk);
    check(n_bn, 384, "bignum count");
  endtask
  //////////////////////////////////////////////////
  // modular engine stand-in: answers two cycles after the last word
  always @(posedge mclk) begin
    last_d  <= bn.valid && bn.last;
    bn_done <= last_d;
    if (bn.valid === 1'b1) begin
      n_bn++;
      check(bn.data, mem_i.rec[FBASE[bn.field] + 9'(bn.index)], "bignum word");
    end
  end
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  // about 10 runs of under 3000 cycles each
  initial begin
    #400000;
    n_mismatch++;
    end_sim();
  end
  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {bn_done, last_d, delay, n_mismatch, tests_run, n_bn} = '0;
    bn_pass = 1'b1;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    apb(1'b0, esc_pkg::A_STATUS, 32'h0);
    check(rd, 32'h0, "status at reset");
    check({pready, irq, fail, mem.req}, 4'h8, "pins at reset");
    apb(1'b1, esc_pkg::A_BASE, 32'h0000_1234);
    apb(1'b0, esc_pkg::A_BASE, 32'h0);
    check(rd, 32'h0000_1000, "base");
    apb(1'b1, esc_pkg::A_INT_MASK, 32'h1);
    build();
    delay <= 4'h3;
    run(1'b1);
    apb(1'b0, esc_pkg::A_STATUS, 32'h0);
    check(rd, 32'h2, "status pass");
    check({irq, fail}, 2'h2, "irq and fail");
    for (int k = 0; k < 11; k++) begin
      apb(1'b0, ROWS[k][16:9], 32'h0);
      check(rd, mem_i.rec[ROWS[k][8:0]], "field");
    end
    apb(1'b0, 8'hfc, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, 8'hfc, 32'h1);
    check(err, 1'b1, "unmapped write");
    apb(1'b1, esc_pkg::A_INT_STAT, 32'h3);
    @(posedge mclk);
    check(irq, 1'b0, "irq clear");
    apb(1'b1, esc_pkg::A_INT_MASK, 32'h2);
    for (int k = 0; k < 9; k++) begin
      build();
      mem_i.rec[BAD[k][52:44]] = BAD[k][43:12];
      delay <= 4'(k % 3);
      run(!BAD[k][8]);
      apb(1'b0, esc_pkg::A_STATUS, 32'h0);
      check(rd, {20'h0, BAD[k][11:0]}, "status");
      check({irq, fail}, {2{BAD[k][2]}}, "irq and fail");
      apb(1'b1, esc_pkg::A_INT_STAT, 32'h3);
    end
    build();
    apb(1'b1, esc_pkg::A_CTRL, 32'h1);
    repeat (50) @(posedge mclk);
    apb(1'b0, esc_pkg::A_STATUS, 32'h0);
    check(rd, 32'h1, "status busy");
    arst_n <= 1'b0;
    @(posedge mclk);
    check({mem.req, bn.valid, fail}, 3'h0, "outputs in reset");
    arst_n <= 1'b1;
    apb(1'b0, esc_pkg::A_BASE, 32'h0);
    check(rd, 32'h0, "base after reset");
    end_sim();
  end
endmodule
